// [teach_map.vh]
// Functional notes
// RL1 - after reset, working step data is reloaded from the flash copy
// RL2 - only a flash commit command copies working data into flash
// RL3 - a change while the selected axis is busy is refused with an error
// RL4 - status word bit zero shows busy of the selected axis
// RL5 - axis selector: zero is the X axis, one is the Y axis
// RL6 - each single address or speed value is one 32-bit word
// RL7 - address/speed item selector: zero is address, one is speed
// RL8 - storage selector: zero writes RAM only, one writes flash too
// RL9 - multi-step change covers up to sixteen steps: transfer, then apply
// RL10 - host leaves a short gap between transfer and apply
// RL11 - transfer buffer holds one 32-bit value per step
// RL12 - apply carries start step and count; count may differ from transfer count
// RL13 - host spaces successive single-step commands by a delay
// RL14 - generic item teach writes RAM only, lost on reset unless committed
// RL15 - generic item teach changes one item; host repeats with short gaps
// RL16 - item codes 1 to 16 from address through repeat step
// RL17 - address item is any signed 32-bit pulse count
// RL18 - speed 1 to 2,000,000; dwell, motion code, turns 0 to 65,535
// RL19 - pattern 0..2, coordinate 0..1, arc mode 0..2
// RL20 - method 0 single, 1 repeat; control 0 position, 1 speed
// RL21 - arc size 0..1, arc direction 0 clockwise, 1 counter-clockwise
// RL22 - host should limit flash commits to spare flash wear
// RL23 - bad item code, step or value flags an error, data unchanged
`ifndef TEACH_MAP_VH
`define TEACH_MAP_VH

// register offsets
`define OFF_CMD      8'h00
`define OFF_DATA     8'h04
`define OFF_ARG      8'h08
`define OFF_STATUS   8'h0c
`define OFF_SNAP     8'h10
`define OFF_RDBACK   8'h14
`define OFF_BLK      8'h40
`define BLK_LAST     8'h7c

// argument fields
`define ARG_AXIS     0
`define ARG_SEL      1
`define ARG_STORE    2
`define ARG_CODE_LO  4
`define ARG_CODE_HI  8
`define ARG_STEP_LO  16
`define ARG_STEP_HI  23
`define ARG_CNT_LO   24
`define ARG_CNT_HI   28

// command opcodes
`define OP_SINGLE    3'h1
`define OP_XFER      3'h2
`define OP_APPLY     3'h3
`define OP_ITEM      3'h4
`define OP_COMMIT    3'h5
`define OP_STATUS    3'h6
`define OP_CLR_ERR   3'h7

// item codes
`define CODE_ADDR    5'h01
`define CODE_SPEED   5'h03

// error codes
`define ERR_NONE     4'h0
`define ERR_BUSY     4'h1
`define ERR_VALUE    4'h2
`define ERR_STEP     4'h3
`define ERR_ENGINE   4'h4
`define ERR_NOXFER   4'h5

// limits
`define STEP_MAX     150
`define BLK_MAX      16
`define SPEED_MAX    32'h001e8480
`define WORD_MAX     32'h0000ffff

`endif

// [positioning_data_teach_unit.v]
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "teach_map.vh"
module positioning_data_teach_unit #(
  parameter STEPS = `STEP_MAX,
  parameter BLK   = `BLK_MAX
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        we,
  input  wire        re,
  output reg  [31:0] rdata,
  // axis busy pins, bit0 x, bit1 y
  input  wire [1:0]  axis_busy,
  // status outputs
  output reg         error,
  output reg         engine_busy
);

  localparam ST_IDLE   = 2'd0;
  localparam ST_LOAD   = 2'd1;
  localparam ST_COMMIT = 2'd2;
  localparam ST_APPLY  = 2'd3;
  localparam DEPTH     = 8192;

  reg  [31:0] ram_mem   [0:DEPTH-1];
  reg  [31:0] flash_mem [0:DEPTH-1];
  reg  [31:0] stage_q   [0:BLK-1];
  reg  [31:0] xbuf_q    [0:BLK-1];
  reg  [1:0]  s1_q;
  reg  [1:0]  s2_q;
  reg  [1:0]  s3_q;
  reg  [1:0]  busy_q;
  reg  [1:0]  state_q;
  reg  [12:0] ptr_q;
  reg  [31:0] data_q;
  reg  [31:0] arg_q;
  reg  [31:0] snap_q;
  reg  [3:0]  err_code_q;
  reg  [4:0]  xcnt_q;
  reg  [12:0] ap_idx_q;
  reg  [4:0]  ap_n_q;
  reg  [4:0]  ap_i_q;
  reg         ap_fl_q;
  reg  [4:0]  ap_code_q;
  reg         cm_axis_q;
  reg  [3:0]  cmd_err;
  reg         ram_we;
  reg  [12:0] ram_wa;
  reg  [31:0] ram_wd;
  reg         fl_we;
  reg  [12:0] fl_wa;
  reg  [31:0] fl_wd;
  reg  [12:0] cmd_idx;
  reg  [4:0]  cmd_code;

  wire        axis     = arg_q[`ARG_AXIS];
  wire [4:0]  arg_code = arg_q[`ARG_CODE_HI:`ARG_CODE_LO];
  wire [7:0]  arg_step = arg_q[`ARG_STEP_HI:`ARG_STEP_LO];
  wire [4:0]  arg_cnt  = arg_q[`ARG_CNT_HI:`ARG_CNT_LO];
  wire        cmd_wr   = we && (addr == `OFF_CMD);
  wire [2:0]  op       = wdata[2:0];
  wire        is_chg   = (op == `OP_SINGLE) || (op == `OP_APPLY) || (op == `OP_ITEM);
  wire        step_ok  = (arg_step >= 8'd1) && (arg_step <= STEPS);
  wire [8:0]  ap_end   = {1'b0, arg_step} + {4'h0, arg_cnt};
  wire        blk_hit  = (addr >= `OFF_BLK) && (addr <= `BLK_LAST);
  wire [3:0]  blk_i    = addr[5:2];
  wire [31:0] ap_val   = xbuf_q[ap_i_q[3:0]];
  wire        ap_ok    = val_ok(ap_code_q, ap_val);
  wire        ap_last  = (ap_i_q == ap_n_q - 5'd1);
  wire [12:0] cm_idx   = {cm_axis_q, ptr_q[11:0]};
  wire        cmd_go   = cmd_wr && (cmd_err == `ERR_NONE);

  // range check per item code
  function val_ok;
    input [4:0]  code;
    input [31:0] v;
    begin
      // RL16 item codes one to sixteen
      case (code)
        // RL17 any signed address
        5'd1, 5'd2: val_ok = 1'b1;
        // RL18 speed range
        5'd3: val_ok = (v >= 32'h1) && (v <= `SPEED_MAX);
        5'd4, 5'd5, 5'd6: val_ok = (v <= `WORD_MAX);
        // RL20 RL21 two-valued items
        5'd7, 5'd8, 5'd10, 5'd11, 5'd15: val_ok = (v <= 32'h1);
        // RL19 three-valued items, codes 9 and 14; codes 12 and 13 take 0 to 3
        5'd9, 5'd14: val_ok = (v <= 32'h2);
        5'd12, 5'd13: val_ok = (v <= 32'h3);
        5'd16: val_ok = (v >= 32'h1) && (v <= STEPS);
        default: val_ok = 1'b0;
      endcase
    end
  endfunction

  // busy pin synchronisers
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : sync
      always @(posedge clk) begin
        if (reset) begin
          s1_q[g]   <= 1'b0;
          s2_q[g]   <= 1'b0;
          s3_q[g]   <= 1'b0;
          busy_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= axis_busy[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            busy_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  // command check
  always @* begin
    // RL7 select address or speed
    cmd_code = (op == `OP_SINGLE) ? (arg_q[`ARG_SEL] ? `CODE_SPEED : `CODE_ADDR) : arg_code;
    // RL5 axis in top index bit
    cmd_idx  = {axis, arg_step, cmd_code[3:0] - 4'h1};
    cmd_err  = `ERR_NONE;
    if (state_q != ST_IDLE && op != `OP_STATUS && op != `OP_CLR_ERR) begin
      cmd_err = `ERR_ENGINE;
    // RL3 refuse change while busy
    end else if (is_chg && busy_q[axis]) begin
      cmd_err = `ERR_BUSY;
    end else begin
      case (op)
        `OP_SINGLE, `OP_ITEM: begin
          // RL23 bad step or value
          if (!step_ok) begin
            cmd_err = `ERR_STEP;
          end else if (!val_ok(cmd_code, data_q)) begin
            cmd_err = `ERR_VALUE;
          end
        end
        `OP_XFER: begin
          // RL9 at most sixteen steps
          if (arg_cnt == 5'd0 || arg_cnt > BLK) begin
            cmd_err = `ERR_STEP;
          end
        end
        `OP_APPLY: begin
          // RL12 count up to transferred count
          if (xcnt_q == 5'd0) begin
            cmd_err = `ERR_NOXFER;
          end else if (!step_ok || arg_cnt == 5'd0 || arg_cnt > xcnt_q || ap_end > STEPS + 1) begin
            cmd_err = `ERR_STEP;
          end
        end
        default: cmd_err = `ERR_NONE;
      endcase
    end
  end

  // memory write sources
  always @* begin
    ram_we = 1'b0;
    ram_wa = cmd_idx;
    ram_wd = data_q;
    fl_we  = 1'b0;
    fl_wa  = cmd_idx;
    fl_wd  = data_q;
    case (state_q)
      ST_LOAD: begin
        // RL1 reload from flash
        ram_we = 1'b1;
        ram_wa = ptr_q;
        ram_wd = flash_mem[ptr_q];
      end
      ST_COMMIT: begin
        // RL2 copy ram to flash
        fl_we = 1'b1;
        fl_wa = cm_idx;
        fl_wd = ram_mem[cm_idx];
      end
      ST_APPLY: begin
        ram_we = ap_ok;
        ram_wa = ap_idx_q;
        ram_wd = ap_val;
        fl_we  = ap_ok && ap_fl_q;
        fl_wa  = ap_idx_q;
        fl_wd  = ap_val;
      end
      default: begin
        if (cmd_go && (op == `OP_SINGLE || op == `OP_ITEM)) begin
          ram_we = 1'b1;
          // RL8 storage selector; RL14 item teach to ram only
          fl_we  = (op == `OP_SINGLE) && arg_q[`ARG_STORE];
        end
      end
    endcase
  end

  always @(posedge clk) begin
    if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
    if (fl_we) begin
      flash_mem[fl_wa] <= fl_wd;
    end
  end

  // control and engine
  integer i;
  always @(posedge clk) begin
    if (reset) begin
      state_q     <= ST_LOAD;
      ptr_q       <= 13'h0000;
      data_q      <= 32'h00000000;
      arg_q       <= 32'h00000000;
      snap_q      <= 32'h00000000;
      err_code_q  <= `ERR_NONE;
      error       <= 1'b0;
      engine_busy <= 1'b1;
      xcnt_q      <= 5'h00;
      ap_idx_q    <= 13'h0000;
      ap_n_q      <= 5'h00;
      ap_i_q      <= 5'h00;
      ap_fl_q     <= 1'b0;
      ap_code_q   <= 5'h00;
      cm_axis_q   <= 1'b0;
      for (i = 0; i < BLK; i = i + 1) begin
        stage_q[i] <= 32'h00000000;
        xbuf_q[i]  <= 32'h00000000;
      end
    end else begin
      // RL6 one 32-bit data word
      if (we && addr == `OFF_DATA) begin
        data_q <= wdata;
      end
      if (we && addr == `OFF_ARG) begin
        arg_q <= wdata;
      end
      if (we && blk_hit) begin
        stage_q[blk_i] <= wdata;
      end
      if (cmd_go && op == `OP_XFER) begin
        // RL11 one word per step
        for (i = 0; i < BLK; i = i + 1) begin
          xbuf_q[i] <= stage_q[i];
        end
        xcnt_q <= arg_cnt;
      end
      if (cmd_go && op == `OP_STATUS) begin
        // RL4 busy in bit zero
        snap_q <= {20'h0, err_code_q, 6'h0, (state_q != ST_IDLE), busy_q[axis]};
      end
      case (state_q)
        ST_LOAD: begin
          ptr_q <= ptr_q + 13'h0001;
          if (ptr_q == DEPTH - 1) begin
            state_q <= ST_IDLE;
          end
        end
        ST_COMMIT: begin
          ptr_q <= ptr_q + 13'h0001;
          if (ptr_q[11:0] == 12'hfff) begin
            state_q <= ST_IDLE;
          end
        end
        ST_APPLY: begin
          ap_i_q   <= ap_i_q + 5'd1;
          ap_idx_q <= ap_idx_q + 13'h0010;
          if (ap_last) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          if (cmd_go && op == `OP_COMMIT) begin
            state_q   <= ST_COMMIT;
            ptr_q     <= 13'h0000;
            cm_axis_q <= axis;
          end
          if (cmd_go && op == `OP_APPLY) begin
            state_q   <= ST_APPLY;
            ap_code_q <= arg_q[`ARG_SEL] ? `CODE_SPEED : `CODE_ADDR;
            ap_idx_q  <= {axis, arg_step, (arg_q[`ARG_SEL] ? 4'h2 : 4'h0)};
            ap_n_q    <= arg_cnt;
            ap_i_q    <= 5'd0;
            ap_fl_q   <= arg_q[`ARG_STORE];
          end
        end
      endcase
      engine_busy <= (state_q != ST_IDLE) && !((state_q == ST_LOAD && ptr_q == DEPTH - 1) ||
                     (state_q == ST_COMMIT && ptr_q[11:0] == 12'hfff) || (state_q == ST_APPLY && ap_last)) ||
                     (cmd_go && (op == `OP_COMMIT || op == `OP_APPLY));
      // RL23 flag error, set wins over clear
      if (cmd_wr && cmd_err != `ERR_NONE) begin
        error      <= 1'b1;
        err_code_q <= cmd_err;
      end else if (state_q == ST_APPLY && !ap_ok) begin
        error      <= 1'b1;
        err_code_q <= `ERR_VALUE;
      end else if (cmd_go && op == `OP_CLR_ERR) begin
        error      <= 1'b0;
        err_code_q <= `ERR_NONE;
      end
    end
  end

  // read data, one cycle after strobe
  always @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (re) begin
      if (blk_hit) begin
        rdata <= stage_q[blk_i];
      end else begin
        case (addr)
          `OFF_DATA:   rdata <= data_q;
          `OFF_ARG:    rdata <= arg_q;
          `OFF_STATUS: rdata <= {20'h0, err_code_q, 4'h0, error, engine_busy, busy_q};
          `OFF_SNAP:   rdata <= snap_q;
          `OFF_RDBACK: rdata <= ram_mem[{axis, arg_step, arg_code[3:0] - 4'h1}];
          default:     rdata <= 32'h00000000;
        endcase
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule

// [axis_motion_model.sv]
`timescale 1ns/1ps
module axis_motion_model (
  // clock
  input  wire       clk,
  // run request and busy pins
  input  wire [1:0] run,
  output reg  [1:0] axis_busy
);
  initial axis_busy = 2'h0;
  always @(posedge clk) begin
    axis_busy <= run;
  end
endmodule

// [teach_unit_assertions.sv]
`timescale 1ns/1ps
module teach_unit_checker #(
  parameter STEPS = 150,
  parameter BLK   = 16
) (
  // clock and reset
  input wire        clk,
  input wire        reset,
  // register port
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        we,
  input wire        re,
  input wire [31:0] rdata,
  // pins and flags
  input wire [1:0]  axis_busy,
  input wire        error,
  input wire        engine_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire cmd = we && addr == 8'h00 && !engine_busy;
  wire clr = we && addr == 8'h00 && wdata[2:0] == 3'h7;
  chk_reload_start: assert property ($fell(reset) |-> engine_busy [*8])
    else $error("no reload after reset");
  chk_rdata_quiet: assert property (!$past(re) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  chk_status_pins: assert property ($stable(axis_busy) [*6] ##0 (re && addr == 8'h0c)
    |=> rdata[1:0] == $past(axis_busy))
    else $error("status busy bits wrong");
  chk_status_flags: assert property (re && addr == 8'h0c |=> rdata[3:2] == $past({error, engine_busy}))
    else $error("status flag bits wrong");
  chk_busy_refuse: assert property ((axis_busy == 2'h3) [*6] ##0 (cmd && wdata[2:0] inside {1, 3, 4})
    |=> error)
    else $error("change while busy accepted");
  chk_commit_run: assert property (cmd && wdata[2:0] == 3'h5 |=> engine_busy [*8])
    else $error("commit did not run");
  chk_err_sticky: assert property (error && !clr |=> error)
    else $error("error flag dropped");
  chk_clear_err: assert property (clr && !engine_busy |=> !error)
    else $error("error not cleared");
  chk_engine_refuse: assert property (we && addr == 8'h00 && engine_busy && wdata[2:0] inside {1, 4, 5}
    |=> error)
    else $error("command during engine run accepted");
endmodule

bind positioning_data_teach_unit teach_unit_checker #(.STEPS(STEPS), .BLK(BLK)) chk (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .axis_busy(axis_busy), .error(error),
  .engine_busy(engine_busy));

// [positioning_data_teach_unit_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module positioning_data_teach_unit_tb;
  reg         clk, reset, we, re;
  reg  [7:0]  addr;
  reg  [31:0] wdata, got;
  reg  [1:0]  run;
  wire [31:0] rdata;
  wire [1:0]  axis_busy;
  wire        error, engine_busy;
  integer     err_total = 0, n_tests = 0, cyc = 0, i;
  reg  [31:0] vals [0:7];
  reg  [4:0]  codes [0:3];

  positioning_data_teach_unit dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .axis_busy(axis_busy), .error(error), .engine_busy(engine_busy));
  axis_motion_model far (.clk(clk), .run(run), .axis_busy(axis_busy));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task end_sim;
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  function [31:0] arg(input ax, input sel, input st, input [4:0] code, input [7:0] step, input [4:0] cnt);
    arg = {3'h0, cnt, step, 7'h00, code, 1'b0, st, sel, ax};
  endfunction

  task wr(input [7:0] a, input [31:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input [7:0] a);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    got = rdata;
    @(posedge clk);
  endtask

  task tch(input [2:0] op, input [31:0] a, input [31:0] d);
    wr(8'h04, d);
    wr(8'h08, a);
    wr(8'h00, {29'h0, op});
  endtask

  task rb(input [31:0] a);
    wr(8'h08, a);
    rd(8'h14);
  endtask

  task idle;
    do @(posedge clk); while (engine_busy !== 1'b0);
  endtask

  task rst;
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    idle;
  endtask

  initial begin
    {reset, we, re, addr, wdata, run} = {1'b1, 44'h0};
    codes[0] = 4; codes[1] = 9; codes[2] = 14; codes[3] = 16;
    vals[0] = 65535; vals[1] = 65536; vals[2] = 2; vals[3] = 3;
    vals[4] = 2; vals[5] = 3; vals[6] = 150; vals[7] = 151;
    rst;
    tch(1, arg(0, 0, 0, 1, 1, 0), 100);
    tch(1, arg(0, 0, 0, 1, 12, 0), 5);
    tch(4, arg(0, 0, 0, 4, 3, 0), 50);
    tch(5, arg(0, 0, 0, 1, 1, 0), 0);
    `CHK("commit", 1'b1, engine_busy)
    wr(8'h00, 32'h4);
    `CHK("engine refuse", 1'b1, error)
    idle;
    wr(8'h00, 32'h7);
    tch(4, arg(0, 0, 0, 4, 3, 0), 60);
    // wr leaves a gap between commands
    tch(1, arg(0, 0, 1, 1, 4, 0), 77);
    tch(1, arg(0, 0, 0, 1, 1, 0), 32'h80000000);
    rb(arg(0, 0, 0, 1, 1, 0));
    `CHK("addr min", 32'h80000000, got)
    rst;
    rb(arg(0, 0, 0, 1, 1, 0));
    `CHK("reload", 32'd100, got)
    rb(arg(0, 0, 0, 4, 3, 0));
    `CHK("item lost", 32'd50, got)
    rb(arg(0, 0, 0, 1, 4, 0));
    `CHK("flash store", 32'd77, got)
    tch(1, arg(0, 1, 0, 3, 2, 0), 2000000);
    rb(arg(0, 1, 0, 3, 2, 0));
    `CHK("speed max", 32'd2000000, got)
    tch(1, arg(0, 1, 0, 3, 2, 0), 2000001);
    `CHK("speed range", 1'b1, error)
    rb(arg(0, 1, 0, 3, 2, 0));
    `CHK("speed kept", 32'd2000000, got)
    wr(8'h00, 32'h7);
    `CHK("clear", 1'b0, error)
    for (i = 0; i < 4; i++) begin
      tch(4, arg(0, 0, 0, codes[i], 5, 0), vals[2 * i]);
      rb(arg(0, 0, 0, codes[i], 5, 0));
      `CHK("item", vals[2 * i], got)
      tch(4, arg(0, 0, 0, codes[i], 5, 0), vals[2 * i + 1]);
      `CHK("item range", 1'b1, error)
      rb(arg(0, 0, 0, codes[i], 5, 0));
      `CHK("item kept", vals[2 * i], got)
      wr(8'h00, 32'h7);
    end
    run <= 2'h3;
    repeat (6) @(posedge clk);
    tch(1, arg(0, 0, 0, 1, 1, 0), 9);
    `CHK("busy refuse", 1'b1, error)
    rb(arg(0, 0, 0, 1, 1, 0));
    `CHK("busy kept", 32'd100, got)
    wr(8'h00, 32'h7);
    rd(8'h0c);
    `CHK("busy bit", 1'b1, got[0])
    tch(6, arg(0, 0, 0, 1, 1, 0), 0);
    rd(8'h10);
    `CHK("snap busy", 1'b1, got[0])
    `CHK("snap err", 4'h0, got[11:8])
    run <= 2'h1;
    repeat (6) @(posedge clk);
    tch(1, arg(1, 0, 0, 1, 1, 0), 7);
    `CHK("y axis", 1'b0, error)
    rb(arg(1, 0, 0, 1, 1, 0));
    `CHK("y data", 32'd7, got)
    run <= 2'h0;
    wr(8'h40, 11);
    wr(8'h44, 22);
    wr(8'h48, 33);
    tch(2, arg(0, 0, 0, 1, 10, 3), 0);
    repeat (4) @(posedge clk);
    tch(3, arg(0, 0, 0, 1, 10, 2), 0);
    idle;
    rb(arg(0, 0, 0, 1, 10, 0));
    `CHK("blk 0", 32'd11, got)
    rb(arg(0, 0, 0, 1, 11, 0));
    `CHK("blk 1", 32'd22, got)
    rb(arg(0, 0, 0, 1, 12, 0));
    `CHK("blk cnt", 32'd5, got)
    end_sim;
  end
endmodule
